// ---- core/adcrb_pkg.sv ----
package adcrb_pkg;

  // sizes of the bank
  localparam int NGRP     = 2;   // channel groups, one map each
  localparam int CH       = 8;   // channels per group
  localparam int ADDR_W   = 10;  // control bus word address
  localparam int DATA_W   = 16;  // control bus data
  localparam int SAMPLE_W = 12;  // adc sample

  // field positions of the hi_processing_config word
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 2;
  localparam int PULSES_LSB = 3;
  localparam int PULSES_W   = 3;
  localparam int MASK_LSB   = 8;

  // version word layout
  localparam int VER_W   = 15;
  localparam int RES_BIT = 15;

  // register widths
  localparam int WIN_W  = 9;
  localparam int LOOK_W = 11;
  localparam int PRE_W  = 12;
  localparam int POST_W = 13;
  localparam int THR_W  = 12;
  localparam int END_W  = 12;
  localparam int CAP_W  = 8;

  // overrun status bits of the second group
  localparam int OVR_PRIMARY    = 0;
  localparam int OVR_SECONDARY  = 1;
  localparam int OVR_PROCESSING = 2;
  localparam int OVR_W          = 3;

  // processing modes
  typedef enum logic [MODE_W-1:0] {
    ADCRB_MODE_RAW      = 2'h0,
    ADCRB_MODE_PULSE    = 2'h1,
    ADCRB_MODE_INTEGRAL = 2'h2
  } adcrb_mode_t;

  typedef logic [ADDR_W-1:0] adcrb_addr_t;

  // word offsets, index 0 = channels 0-7, index 1 = channels 8-15
  localparam adcrb_addr_t VERSION_OFS   = 10'h000;
  localparam adcrb_addr_t TRIGCNT_OFS   = 10'h001;
  localparam adcrb_addr_t HI_STATUS_OFS = 10'h200;
  localparam adcrb_addr_t CFG_OFS  [NGRP] = '{10'h002, 10'h201};
  localparam adcrb_addr_t WIN_OFS  [NGRP] = '{10'h003, 10'h202};
  localparam adcrb_addr_t LOOK_OFS [NGRP] = '{10'h004, 10'h203};
  localparam adcrb_addr_t PRE_OFS  [NGRP] = '{10'h005, 10'h204};
  localparam adcrb_addr_t POST_OFS [NGRP] = '{10'h006, 10'h205};
  localparam adcrb_addr_t THR_OFS  [NGRP] = '{10'h007, 10'h206};
  localparam adcrb_addr_t END_OFS  [NGRP] = '{10'h00f, 10'h20e};
  localparam adcrb_addr_t CAP_OFS  [NGRP] = '{10'h00f, 10'h20f};

  // reset values
  localparam logic [DATA_W-1:0] RST_CFG  = 16'h0000;
  localparam logic [WIN_W-1:0]  RST_WIN  = 9'h006;
  localparam logic [LOOK_W-1:0] RST_LOOK = 11'h000;
  localparam logic [PRE_W-1:0]  RST_PRE  = 12'h002;
  localparam logic [POST_W-1:0] RST_POST [NGRP] = '{13'h0003, 13'h0004};
  localparam logic [THR_W-1:0]  RST_THR  = 12'h000;
  localparam logic [END_W-1:0]  RST_END  = 12'h000;
  localparam logic [CAP_W-1:0]  RST_CAP  = 8'h00;

  // processing counts
  localparam logic [PRE_W-1:0]  PRE_MIN         = 12'h002;
  localparam logic [POST_W:0]   POST_ODD_EXTRA  = 14'h0001;
  localparam logic [POST_W:0]   POST_EVEN_EXTRA = 14'h0002;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED  = 16'h0000;

endpackage

// ---- core/adcrb_cond_if.sv ----
`timescale 1ns/1ns
// hi_processing_config that one channel group's sample conditioner needs
interface adcrb_cond_if;
  import adcrb_pkg::*;
  logic [CH-1:0]            chan_mask;  // 1 forces channel to zero
  logic [CH-1:0][THR_W-1:0] thr;        // per-channel threshold
  adcrb_mode_t              mode;       // processing mode

  modport cfg  (output chan_mask, output thr, output mode);
  modport cond (input chan_mask, input thr, input mode);
endinterface

// ---- core/adcrb_chan_cond.sv ----
`timescale 1ns/1ns
module adcrb_chan_cond (
  // clock and reset
  input  wire logic                                           clock,
  input  wire logic                                           rst,
  // hi_processing_config
  adcrb_cond_if.cond                                          cif,
  // samples
  input  wire logic [adcrb_pkg::CH-1:0][adcrb_pkg::SAMPLE_W-1:0] sample_in,
  output logic      [adcrb_pkg::CH-1:0][adcrb_pkg::SAMPLE_W-1:0] sample_out,
  output logic      [adcrb_pkg::CH-1:0]                        over_thr
);
  import adcrb_pkg::*;

  logic [CH-1:0][SAMPLE_W-1:0] sample_reg;   // masked samples
  logic [CH-1:0][SAMPLE_W-1:0] sample_next;
  logic [CH-1:0]               over_reg;     // above threshold
  logic [CH-1:0]               over_next;

  ///////////////////////////////////////////////////////////////////////////
  // per-channel masking and threshold compare
  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_ch
      always_comb begin
        sample_next[c] = cif.chan_mask[c] ? '0 : sample_in[c];
        // own threshold compare
        // raw mode needs no crossings, so the flag stays quiet there
        over_next[c]   = !cif.chan_mask[c] &&
                         (cif.mode != ADCRB_MODE_RAW) &&
                         (sample_in[c] > cif.thr[c]);
      end
    end
  endgenerate

  // register the conditioned data
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_reg <= '0;
      over_reg   <= '0;
    end else begin
      sample_reg <= sample_next;
      over_reg   <= over_next;
    end
  end

  assign sample_out = sample_reg;
  assign over_thr   = over_reg;
endmodule

// ---- core/adcrb_status.sv ----
`timescale 1ns/1ns
module adcrb_status (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // trigger pin, active low, asynchronous
  input  wire logic                          trig_n_pin,
  // overrun events and read-clear
  input  wire logic [adcrb_pkg::OVR_W-1:0]   ovr_evt,
  input  wire logic                          ovr_clr,
  // status words
  output logic      [adcrb_pkg::DATA_W-1:0]  trig_count,
  output logic      [adcrb_pkg::OVR_W-1:0]   ovr_flags
);
  import adcrb_pkg::*;

  logic              sync1_reg;   // first synchroniser stage
  logic              sync2_reg;   // second stage
  logic              prev_reg;    // for edge detect
  logic [DATA_W-1:0] cnt_reg;     // trigger count
  logic [DATA_W-1:0] cnt_next;
  logic [OVR_W-1:0]  ovr_reg;     // sticky overruns
  logic [OVR_W-1:0]  ovr_next;

  ///////////////////////////////////////////////////////////////////////////
  // next values: count falling trigger edges, hold overruns
  always_comb begin
    // wraps silently after 16 bits
    cnt_next = cnt_reg;
    if (prev_reg && !sync2_reg) begin
      cnt_next = cnt_reg + 1'b1;
    end
    // sticky overrun flags
    // set wins over a read-clear in the same cycle
    ovr_next = (ovr_clr ? '0 : ovr_reg) | ovr_evt;
  end

  // registers; sync stage one feeds stage two only
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
      cnt_reg   <= '0;
      ovr_reg   <= '0;
    end else begin
      sync1_reg <= trig_n_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      cnt_reg   <= cnt_next;
      ovr_reg   <= ovr_next;
    end
  end

  assign trig_count = cnt_reg;
  assign ovr_flags  = ovr_reg;
endmodule

// ---- core/adcrb_top.sv ----
`timescale 1ns/1ns
// Contract
// - version word with resolution flag bit
// - config bits 1:0 pick processing mode
// - bits 5:3 pulse count, pulse modes
// - bits 15:8 zero masked channel samples
// - 11-bit look-back before trigger point
// - pre-count includes threshold point, minimum two
// - report post-count plus one odd, two even
// - second group status flags three overruns
// - 8-bit secondary buffer block capacity
module adcrb_top #(
  // code version is an arbitrary value
  parameter logic [adcrb_pkg::VER_W-1:0] CODE_VERSION = 15'h0001,
  // 1 for 10-bit converters, 0 for 12-bit
  parameter logic                        ADC_IS_10BIT = 1'b0
) (
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst,
  // control bus
  input  wire logic [adcrb_pkg::ADDR_W-1:0]             cb_addr,
  input  wire logic                                     cb_wr,
  input  wire logic                                     cb_rd,
  input  wire logic [adcrb_pkg::DATA_W-1:0]             cb_wdata,
  output logic      [adcrb_pkg::DATA_W-1:0]             cb_rdata,
  output logic                                          cb_rvalid,
  // status events
  input  wire logic                                     trig_n,
  input  wire logic [adcrb_pkg::OVR_W-1:0]              ovr_evt,
  // samples in and conditioned samples out
  input  wire logic [adcrb_pkg::NGRP-1:0][adcrb_pkg::CH-1:0]
                    [adcrb_pkg::SAMPLE_W-1:0]           grp_sample_in,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::CH-1:0]
                    [adcrb_pkg::SAMPLE_W-1:0]           grp_sample_out,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::CH-1:0] grp_over_thr,
  // processing hi_processing_config per group
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::MODE_W-1:0] proc_mode,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::PULSES_W-1:0] pulse_count,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::CH-1:0] chan_mask,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::WIN_W-1:0] window_len,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::WIN_W-1:0] window_report,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::LOOK_W-1:0] lookback,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::PRE_W-1:0] pre_count,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::POST_W-1:0] post_count,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::POST_W:0] post_report,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::END_W-1:0] buf_end_addr,
  output logic      [adcrb_pkg::NGRP-1:0][adcrb_pkg::CAP_W-1:0] block_capacity
);
  import adcrb_pkg::*;

  ///////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when addr falls in the threshold block starting at base
  function automatic logic in_thr(adcrb_addr_t addr, adcrb_addr_t base);
    in_thr = (addr >= base) && (addr < base + adcrb_addr_t'(CH));
  endfunction

  // channel index inside a threshold block
  function automatic logic [2:0] thr_idx(adcrb_addr_t addr,
                                         adcrb_addr_t base);
    adcrb_addr_t diff;
    diff    = addr - base;
    thr_idx = diff[2:0];
  endfunction

  ///////////////////////////////////////////////////////////////////////////
  // hi_processing_config registers

  logic [DATA_W-1:0]         cfg_reg  [NGRP];  // mode, pulses, masks
  logic [DATA_W-1:0]         cfg_next [NGRP];
  logic [WIN_W-1:0]          win_reg  [NGRP];  // trigger window length
  logic [WIN_W-1:0]          win_next [NGRP];
  logic [LOOK_W-1:0]         look_reg [NGRP];  // look-back
  logic [LOOK_W-1:0]         look_next[NGRP];
  logic [PRE_W-1:0]          pre_reg  [NGRP];  // samples before
  logic [PRE_W-1:0]          pre_next [NGRP];
  logic [POST_W-1:0]         post_reg [NGRP];  // samples after
  logic [POST_W-1:0]         post_next[NGRP];
  logic [CH-1:0][THR_W-1:0]  thr_reg  [NGRP];  // energy thresholds
  logic [CH-1:0][THR_W-1:0]  thr_next [NGRP];
  logic [END_W-1:0]          end_reg  [NGRP];  // buffer last address
  logic [END_W-1:0]          end_next [NGRP];
  logic [CAP_W-1:0]          cap_reg  [NGRP];  // block capacity
  logic [CAP_W-1:0]          cap_next [NGRP];

  // write decode: only read/write words take data
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      cfg_next[g]  = cfg_reg[g];
      win_next[g]  = win_reg[g];
      look_next[g] = look_reg[g];
      pre_next[g]  = pre_reg[g];
      post_next[g] = post_reg[g];
      thr_next[g]  = thr_reg[g];
      end_next[g]  = end_reg[g];
      cap_next[g]  = cap_reg[g];
      if (cb_wr) begin
        if (cb_addr == CFG_OFS[g]) begin
          cfg_next[g] = cb_wdata;
        end
        if (cb_addr == WIN_OFS[g]) begin
          win_next[g] = cb_wdata[WIN_W-1:0];
        end
        if (cb_addr == LOOK_OFS[g]) begin
          look_next[g] = cb_wdata[LOOK_W-1:0];
        end
        if (cb_addr == PRE_OFS[g]) begin
          pre_next[g] = cb_wdata[PRE_W-1:0];
        end
        if (cb_addr == POST_OFS[g]) begin
          post_next[g] = cb_wdata[POST_W-1:0];
        end
        if (in_thr(cb_addr, THR_OFS[g])) begin
          thr_next[g][thr_idx(cb_addr, THR_OFS[g])] = cb_wdata[THR_W-1:0];
        end
        // in the first group both words share one offset, so one
        // write loads the last address and the capacity together
        if (cb_addr == END_OFS[g]) begin
          end_next[g] = cb_wdata[END_W-1:0];
        end
        if (cb_addr == CAP_OFS[g]) begin
          cap_next[g] = cb_wdata[CAP_W-1:0];
        end
      end
    end
  end

  // register the hi_processing_config
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int g = 0; g < NGRP; g++) begin
        cfg_reg[g]  <= RST_CFG;
        win_reg[g]  <= RST_WIN;
        look_reg[g] <= RST_LOOK;
        pre_reg[g]  <= RST_PRE;
        post_reg[g] <= RST_POST[g];
        thr_reg[g]  <= {CH{RST_THR}};
        end_reg[g]  <= RST_END;
        cap_reg[g]  <= RST_CAP;
      end
    end else begin
      cfg_reg  <= cfg_next;
      win_reg  <= win_next;
      look_reg <= look_next;
      pre_reg  <= pre_next;
      post_reg <= post_next;
      thr_reg  <= thr_next;
      end_reg  <= end_next;
      cap_reg  <= cap_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // status: trigger count and overrun flags

  logic [DATA_W-1:0] trig_count;   // triggers since reset
  logic [OVR_W-1:0]  ovr_flags;    // sticky overruns
  logic              ovr_clr;      // status read clears

  // reading the overrun word clears it; a new event still lands
  assign ovr_clr = cb_rd && (cb_addr == HI_STATUS_OFS);

  adcrb_status u_status (
    .clock      (clock),
    .rst        (rst),
    .trig_n_pin (trig_n),
    .ovr_evt    (ovr_evt),
    .ovr_clr    (ovr_clr),
    .trig_count (trig_count),
    .ovr_flags  (ovr_flags)
  );

  ///////////////////////////////////////////////////////////////////////////
  // read path, answered one cycle after the strobe

  logic [DATA_W-1:0] rdata_reg;    // read data
  logic [DATA_W-1:0] rdata_next;
  logic              rvalid_reg;   // read answer strobe
  logic              rvalid_next;

  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = cb_rd;
    if (cb_rd) begin
      // unmapped words read as zero
      rdata_next = RDATA_UNMAPPED;
      if (cb_addr == VERSION_OFS) begin
        rdata_next = {ADC_IS_10BIT, CODE_VERSION};
      end
      if (cb_addr == TRIGCNT_OFS) begin
        rdata_next = trig_count;
      end
      if (cb_addr == HI_STATUS_OFS) begin
        rdata_next = {{(DATA_W-OVR_W){1'b0}}, ovr_flags};
      end
      for (int g = 0; g < NGRP; g++) begin
        if (cb_addr == CFG_OFS[g]) begin
          rdata_next = cfg_reg[g];
        end
        if (cb_addr == WIN_OFS[g]) begin
          rdata_next = {{(DATA_W-WIN_W){1'b0}}, win_reg[g]};
        end
        if (cb_addr == LOOK_OFS[g]) begin
          rdata_next = {{(DATA_W-LOOK_W){1'b0}}, look_reg[g]};
        end
        if (cb_addr == PRE_OFS[g]) begin
          rdata_next = {{(DATA_W-PRE_W){1'b0}}, pre_reg[g]};
        end
        if (cb_addr == POST_OFS[g]) begin
          rdata_next = {{(DATA_W-POST_W){1'b0}}, post_reg[g]};
        end
        if (in_thr(cb_addr, THR_OFS[g])) begin
          rdata_next = {{(DATA_W-THR_W){1'b0}},
                        thr_reg[g][thr_idx(cb_addr, THR_OFS[g])]};
        end
        // capacity first, so the shared offset reads the last address
        if (cb_addr == CAP_OFS[g]) begin
          rdata_next = {{(DATA_W-CAP_W){1'b0}}, cap_reg[g]};
        end
        if (cb_addr == END_OFS[g]) begin
          rdata_next = {{(DATA_W-END_W){1'b0}}, end_reg[g]};
        end
      end
    end
  end

  // register the answer
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cb_rdata  = rdata_reg;
  assign cb_rvalid = rvalid_reg;

  ///////////////////////////////////////////////////////////////////////////
  // derived processing values, one cycle behind the registers

  logic [MODE_W-1:0]   mode_reg   [NGRP];  // decoded mode
  logic [MODE_W-1:0]   mode_next  [NGRP];
  logic [PULSES_W-1:0] pulse_reg  [NGRP];  // pulses per window
  logic [PULSES_W-1:0] pulse_next [NGRP];
  logic [WIN_W-1:0]    wrep_reg   [NGRP];  // even window length
  logic [WIN_W-1:0]    wrep_next  [NGRP];
  logic [PRE_W-1:0]    pre_eff_reg [NGRP]; // clamped pre-count
  logic [PRE_W-1:0]    pre_eff_next[NGRP];
  logic [POST_W:0]     prep_reg   [NGRP];  // reported post samples
  logic [POST_W:0]     prep_next  [NGRP];

  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      mode_next[g] = cfg_reg[g][MODE_LSB +: MODE_W];
      if (mode_next[g] == ADCRB_MODE_PULSE ||
          mode_next[g] == ADCRB_MODE_INTEGRAL) begin
        pulse_next[g] = cfg_reg[g][PULSES_LSB +: PULSES_W];
      end else begin
        pulse_next[g] = '0;
      end
      wrep_next[g] = {win_reg[g][WIN_W-1:1], 1'b0};
      // pre-count floor of two
      // a short value would lose the threshold point itself
      pre_eff_next[g] = (pre_reg[g] < PRE_MIN) ? PRE_MIN : pre_reg[g];
      prep_next[g] = {1'b0, post_reg[g]} +
                     (post_reg[g][0] ? POST_ODD_EXTRA : POST_EVEN_EXTRA);
    end
  end

  // register the derived values
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int g = 0; g < NGRP; g++) begin
        mode_reg[g]    <= '0;
        pulse_reg[g]   <= '0;
        wrep_reg[g]    <= '0;
        pre_eff_reg[g] <= PRE_MIN;
        prep_reg[g]    <= '0;
      end
    end else begin
      mode_reg    <= mode_next;
      pulse_reg   <= pulse_next;
      wrep_reg    <= wrep_next;
      pre_eff_reg <= pre_eff_next;
      prep_reg    <= prep_next;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // per-group outputs and sample conditioners

  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi++) begin : g_grp
      adcrb_cond_if cif ();

      // hi_processing_config toward the conditioner
      assign cif.chan_mask = cfg_reg[gi][MASK_LSB +: CH];
      assign cif.thr       = thr_reg[gi];
      assign cif.mode      = adcrb_mode_t'(mode_reg[gi]);

      adcrb_chan_cond u_cond (
        .clock      (clock),
        .rst        (rst),
        .cif        (cif),
        .sample_in  (grp_sample_in[gi]),
        .sample_out (grp_sample_out[gi]),
        .over_thr   (grp_over_thr[gi])
      );

      // register-backed processing settings
      assign proc_mode[gi]      = mode_reg[gi];
      assign pulse_count[gi]    = pulse_reg[gi];
      assign chan_mask[gi]      = cfg_reg[gi][MASK_LSB +: CH];
      assign window_len[gi]     = win_reg[gi];
      assign window_report[gi]  = wrep_reg[gi];
      assign lookback[gi]       = look_reg[gi];
      assign pre_count[gi]      = pre_eff_reg[gi];
      assign post_count[gi]     = post_reg[gi];
      assign post_report[gi]    = prep_reg[gi];
      assign buf_end_addr[gi]   = end_reg[gi];
      assign block_capacity[gi] = cap_reg[gi];
    end
  endgenerate

endmodule

// ---- verif/adcrb_top_props.sv ----
`timescale 1ns/1ns
module adcrb_top_props
  import adcrb_pkg::*;
(
  // clock and reset
  input wire logic                                clock,
  input wire logic                                rst,
  // control bus
  input wire logic [ADDR_W-1:0]                   cb_addr,
  input wire logic                                cb_wr,
  input wire logic                                cb_rd,
  input wire logic [DATA_W-1:0]                   cb_wdata,
  input wire logic [DATA_W-1:0]                   cb_rdata,
  input wire logic                                cb_rvalid,
  // samples
  input wire logic [NGRP-1:0][CH-1:0][SAMPLE_W-1:0] grp_sample_in,
  input wire logic [NGRP-1:0][CH-1:0][SAMPLE_W-1:0] grp_sample_out,
  input wire logic [NGRP-1:0][CH-1:0]             grp_over_thr,
  // hi_processing_config outputs
  input wire logic [NGRP-1:0][MODE_W-1:0]         proc_mode,
  input wire logic [NGRP-1:0][PULSES_W-1:0]       pulse_count,
  input wire logic [NGRP-1:0][CH-1:0]             chan_mask,
  input wire logic [NGRP-1:0][WIN_W-1:0]          window_len,
  input wire logic [NGRP-1:0][WIN_W-1:0]          window_report,
  input wire logic [NGRP-1:0][POST_W-1:0]         post_count,
  input wire logic [NGRP-1:0][POST_W:0]           post_report
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // config write to group 0, two edges before derived outputs move
  sequence cfg_wr0;
    cb_wr && cb_addr == CFG_OFS[0];
  endsequence
  a_rd_answered: assert property (cb_rd |=> cb_rvalid)
    else $error("read got no answer");
  a_no_stray_valid: assert property (cb_rvalid |-> $past(cb_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!cb_rvalid |-> $stable(cb_rdata))
    else $error("read data moved without answer");
  a_mode_follows: assert property (cfg_wr0 |->
    ##2 proc_mode[0] == $past(cb_wdata[1:0], 2))
    else $error("mode not taken from config");
  a_pulse_raw: assert property (proc_mode[0] == 2'h0 |->
    pulse_count[0] == 3'h0) else $error("pulse count in raw mode");
  a_mask_zeroes: assert property (chan_mask[0][0] |=>
    grp_sample_out[0][0] == 12'h000) else $error("masked sample passed");
  a_sample_passes: assert property (!chan_mask[0][1] |=>
    grp_sample_out[0][1] == $past(grp_sample_in[0][1]))
    else $error("sample not passed");
  a_mask_no_hit: assert property (chan_mask[0][0] |=>
    !grp_over_thr[0][0]) else $error("masked channel over threshold");
  // reset release skipped: derived values lag one edge
  a_post_report: assert property ((!$past(rst) &&
    $stable(post_count[0])) |-> post_report[0] == {1'b0, post_count[0]}
    + (post_count[0][0] ? 14'h0001 : 14'h0002))
    else $error("post report wrong");
  a_window_even: assert property ((!$past(rst) &&
    $stable(window_len[0])) |-> window_report[0] ==
    {window_len[0][8:1], 1'b0}) else $error("window report not even");
endmodule
bind adcrb_top adcrb_top_props u_adcrb_top_props (.clock, .rst, .cb_addr,
  .cb_wr, .cb_rd, .cb_wdata, .cb_rdata, .cb_rvalid, .grp_sample_in,
  .grp_sample_out, .grp_over_thr, .proc_mode, .pulse_count, .chan_mask,
  .window_len, .window_report, .post_count, .post_report);

// ---- verif/adcrb_host_bfm.sv ----
`timescale 1ns/1ns
module adcrb_host_bfm
  import adcrb_pkg::*;
(
  // clock
  input wire logic          clock,
  // control bus
  output logic [ADDR_W-1:0] cb_addr,
  output logic              cb_wr,
  output logic              cb_rd,
  output logic [DATA_W-1:0] cb_wdata,
  input wire logic [DATA_W-1:0] cb_rdata,
  input wire logic          cb_rvalid
);
  // idle bus at time zero
  initial begin
    cb_addr = '0;
    cb_wr = 1'b0;
    cb_rd = 1'b0;
    cb_wdata = '0;
  end
  // one-cycle write; released lines show the inverse, not stale data
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock);
    cb_addr = a;
    cb_wdata = d;
    cb_wr = 1'b1;
    @(negedge clock);
    cb_wr = 1'b0;
    cb_addr = ~a;
    cb_wdata = ~d;
  endtask
  // one-cycle read, answer awaited a bounded time
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    @(negedge clock);
    cb_addr = a;
    cb_rd = 1'b1;
    @(negedge clock);
    cb_rd = 1'b0;
    cb_addr = ~a;
    n = 0;
    while (cb_rvalid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = cb_rdata;
  endtask
  function automatic logic [CAP_W-1:0] cap_of(int w);
    return CAP_W'(2016 / (w + 8));
  endfunction
  // last address of the secondary buffer
  function automatic logic [END_W-1:0] end_of(int c, int w);
    return END_W'(c * (w + 6) - 1);
  endfunction
endmodule

// ---- verif/adcrb_top_tb.sv ----
`timescale 1ns/1ns
module adcrb_top_tb;
  import adcrb_pkg::*;
  logic clock, rst, trig_n, cb_wr, cb_rd, cb_rvalid;  // scalars
  logic [ADDR_W-1:0] cb_addr;                   // bus address
  logic [DATA_W-1:0] cb_wdata, cb_rdata, d;     // bus data
  logic [OVR_W-1:0]  ovr_evt;                   // overrun events
  logic [NGRP-1:0][CH-1:0][SAMPLE_W-1:0] s_in, s_out;
  logic [NGRP-1:0][CH-1:0] over_thr, mask;
  logic [NGRP-1:0][MODE_W-1:0]   mode;
  logic [NGRP-1:0][PULSES_W-1:0] pulses;
  logic [NGRP-1:0][WIN_W-1:0]    win_rep;
  logic [NGRP-1:0][PRE_W-1:0]    pre;
  logic [NGRP-1:0][LOOK_W-1:0]   look;
  logic [NGRP-1:0][POST_W:0]     post_rep;
  logic [NGRP-1:0][END_W-1:0]    end_a;
  logic [NGRP-1:0][CAP_W-1:0]    cap;
  int mismatches = 0, tests_run = 0, cycles = 0;
  // version value is arbitrary
  adcrb_top #(.CODE_VERSION(15'h1234), .ADC_IS_10BIT(1'b1)) u_adcrb_top (
    .clock, .rst, .cb_addr, .cb_wr, .cb_rd, .cb_wdata, .cb_rdata, .cb_rvalid,
    .trig_n, .ovr_evt, .grp_sample_in(s_in), .grp_sample_out(s_out),
    .grp_over_thr(over_thr), .proc_mode(mode), .pulse_count(pulses),
    .chan_mask(mask), .window_len(), .window_report(win_rep), .lookback(look),
    .pre_count(pre), .post_count(), .post_report(post_rep),
    .buf_end_addr(end_a), .block_capacity(cap));
  adcrb_host_bfm u_adcrb_host_bfm (.clock, .cb_addr, .cb_wr, .cb_rd,
    .cb_wdata, .cb_rdata, .cb_rvalid);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    u_adcrb_host_bfm.rd(a, d);
    chk(d, e);
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, a run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_ro;
    rdchk(VERSION_OFS, 16'h9234);
    u_adcrb_host_bfm.wr(VERSION_OFS, 16'h0000);
    rdchk(VERSION_OFS, 16'h9234);
    rdchk(WIN_OFS[0], 16'h0006);
    rdchk(POST_OFS[1], 16'h0004);
  endtask
  // every mode, pulses only where they apply
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      u_adcrb_host_bfm.wr(CFG_OFS[0], {8'h01, 2'h0, 3'h5, 1'b0, 2'(m)});
      @(negedge clock);
      chk(mode[0], m);
      chk(pulses[0], (m inside {1, 2}) ? 5 : 0);
      chk(mask[0], 8'h01);
      rdchk(CFG_OFS[0], {8'h01, 2'h0, 3'h5, 1'b0, 2'(m)});
    end
  endtask
  // masked ch0, threshold edge on ch1
  task automatic t_samples;
    u_adcrb_host_bfm.wr(THR_OFS[0] + 10'h001, 16'h0100);
    s_in[0][0] = 12'habc;
    s_in[0][1] = 12'h101;
    @(negedge clock);
    chk(s_out[0][0], 0);
    chk(s_out[0][1], 12'h101);
    chk(over_thr[0][1], 1);
    s_in[0][1] = 12'h100;
    @(negedge clock);
    chk(over_thr[0][1], 0);
  endtask
  // 36 ns window at 250 MHz gives 9 samples
  task automatic t_counts;
    u_adcrb_host_bfm.wr(WIN_OFS[0], 16'h0009);
    u_adcrb_host_bfm.wr(PRE_OFS[0], 16'h0001);
    u_adcrb_host_bfm.wr(POST_OFS[0], 16'h0007);
    @(negedge clock);
    chk(win_rep[0], 8);
    chk(pre[0], 2);
    chk(post_rep[0], 8);
    u_adcrb_host_bfm.wr(POST_OFS[0], 16'h0008);
    @(negedge clock);
    chk(post_rep[0], 10);
    u_adcrb_host_bfm.wr(LOOK_OFS[0], 16'hffff);
    rdchk(LOOK_OFS[0], 16'h07ff);
    chk(look[0], 11'h7ff);
  endtask
  // sticky overruns clear on read; two triggers counted
  task automatic t_status;
    ovr_evt = 3'h5;
    rdchk(HI_STATUS_OFS, 16'h0005);
    ovr_evt = 3'h0;
    rdchk(HI_STATUS_OFS, 16'h0005);
    rdchk(HI_STATUS_OFS, 16'h0000);
    repeat (2) begin
      trig_n = 1'b0;
      repeat (3) @(negedge clock);
      trig_n = 1'b1;
      repeat (3) @(negedge clock);
    end
    rdchk(TRIGCNT_OFS, 16'h0002);
  endtask
  // 10-sample window sizing of the second group
  task automatic t_buffer;
    logic [CAP_W-1:0] c;
    c = u_adcrb_host_bfm.cap_of(10);
    u_adcrb_host_bfm.wr(CAP_OFS[1], 16'(c));
    u_adcrb_host_bfm.wr(END_OFS[1], 16'(u_adcrb_host_bfm.end_of(c, 10)));
    chk(cap[1], 8'h70);
    chk(end_a[1], 12'h6ff);
    rdchk(CAP_OFS[1], 16'h0070);
  endtask
  initial begin
    rst = 1'b1;
    trig_n = 1'b1;
    ovr_evt = '0;
    s_in = '0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    t_reset_ro;
    t_modes;
    t_samples;
    t_counts;
    t_status;
    t_buffer;
    tally_and_finish;
  end
endmodule
